// >>> include/uerp_pkg.sv
`default_nettype none
package uerp_pkg;
    localparam int DATA_W = 8;
    localparam int ERR_W = 3;
    localparam int RXF_W = 11;
    localparam int RXF_DEPTH = 32;
    localparam int CNT_W = 6;

    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IER = 3'h1;
    localparam logic [2:0] OFS_ISR = 3'h2;
    localparam logic [2:0] OFS_LCR = 3'h3;
    localparam logic [2:0] OFS_RESUME1 = 3'h4;
    localparam logic [2:0] OFS_LSR = 3'h5;
    localparam logic [2:0] OFS_MSR = 3'h6;
    localparam logic [2:0] OFS_PAUSE2 = 3'h7;
    localparam logic [2:0] OFS_RESUME2 = 3'h5;
    localparam logic [2:0] OFS_PAUSE1 = 3'h6;

    localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
    localparam int LCR_DIV_BIT = 7;
    localparam int EFR_ENH_BIT = 4;
    localparam int FCR_EN_BIT = 0;
    localparam int FCR_RXRST_BIT = 1;
    localparam int FEATURE_CONTROL_RX_SEL_BIT = 7;
    localparam int IER_RX_BIT = 0;
    localparam int IER_TX_BIT = 1;
    localparam int IER_LS_BIT = 2;
    localparam int IER_MS_BIT = 3;

    localparam logic [7:0] IER_STD_MASK = 8'h0F;
    localparam logic [7:0] IER_ENH_MASK = 8'hFF;
    localparam logic [7:0] DLD_MASK = 8'h0F;
    localparam logic [7:0] EFR_MASK = 8'h3F;
    localparam logic [7:0] FEATURE_CONTROL_MASK = 8'hF4;

    localparam logic [3:0] ISR_LSR = 4'h6;
    localparam logic [3:0] ISR_RXRDY = 4'h4;
    localparam logic [3:0] ISR_TXRDY = 4'h2;
    localparam logic [3:0] ISR_MSR = 4'h0;
    localparam logic [3:0] ISR_NONE = 4'h1;

    localparam int LSR_DR = 0;
    localparam int LSR_OE = 1;
    localparam int LSR_THRE = 5;
    localparam int LSR_TEMT = 6;
    localparam int LSR_GERR = 7;

    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [7:0] RX_TRIG_RST = 8'h01;
    localparam logic [7:0] TX_TRIG_RST = 8'h00;
    // Identity values are arbitrary.
    localparam logic [7:0] REVISION_CODE = 8'h01;
    localparam logic [7:0] DEVICE_CODE = 8'h07;
endpackage
`default_nettype wire

// >>> core/uerp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module uerp_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 32,
    parameter int CW = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CW-1:0] count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic rdy_ff, nxt_rdy;
    logic push, pop;

    assign push = in_valid && rdy_ff && !flush;
    assign pop = out_valid && out_ready && !flush;
    assign out_valid = cnt_ff != '0;
    assign out_data = mem[rd_ptr_ff];
    assign in_ready = rdy_ff;
    assign count = cnt_ff;

    always_comb begin
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_cnt = cnt_ff;
        if (flush) begin
            nxt_wr_ptr = '0;
            nxt_rd_ptr = '0;
            nxt_cnt = '0;
        end else begin
            if (push) begin
                nxt_wr_ptr = AW'(wr_ptr_ff + 1'b1);
            end
            if (pop) begin
                nxt_rd_ptr = AW'(rd_ptr_ff + 1'b1);
            end
            nxt_cnt = CW'(cnt_ff + CW'(push) - CW'(pop));
        end
        nxt_rdy = nxt_cnt < CW'(DEPTH);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b1;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end
endmodule
`default_nettype wire

// >>> core/uerp_regs.sv
`timescale 1ns/1ns
`default_nettype none
module uerp_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic host_cs,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [2:0] host_addr,
    input wire logic [uerp_pkg::DATA_W-1:0] host_wdata,
    output logic [uerp_pkg::DATA_W-1:0] host_rdata,
    output logic irq,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [uerp_pkg::DATA_W-1:0] rx_data,
    input wire logic [uerp_pkg::ERR_W-1:0] rx_err,
    output logic tx_wr,
    output logic [uerp_pkg::DATA_W-1:0] tx_data,
    input wire logic tx_empty,
    input wire logic tsr_empty,
    input wire logic [uerp_pkg::DATA_W-1:0] tx_level,
    input wire logic [uerp_pkg::DATA_W-1:0] modem_status,
    input wire logic modem_int,
    output logic [15:0] baud_div,
    output logic [3:0] baud_frac,
    output logic [uerp_pkg::DATA_W-1:0] line_ctrl,
    output logic [uerp_pkg::DATA_W-1:0] tx_trigger
);
    import uerp_pkg::*;

    function automatic logic [7:0] pad8(input logic [CNT_W-1:0] v);
        pad8 = {{(8 - CNT_W){1'b0}}, v};
    endfunction

    logic [7:0] lcr_ff, nxt_lcr, ier_ff, nxt_ier, dll_ff, nxt_dll, dlm_ff, nxt_dlm;
    logic [7:0] dld_ff, nxt_dld, efr_ff, nxt_efr, feature_control_ff, nxt_feature_control;
    logic [7:0] rx_trig_ff, nxt_rx_trig, tx_trig_ff, nxt_tx_trig;
    logic [7:0] res1_ff, nxt_res1, res2_ff, nxt_res2, pau1_ff, nxt_pau1, pau2_ff, nxt_pau2;
    logic [7:0] rdata_ff, nxt_rdata, tx_data_ff, nxt_tx_data;
    logic fifo_en_ff, nxt_fifo_en, overrun_ff, nxt_overrun, irq_ff, nxt_irq;
    logic tx_wr_ff, nxt_tx_wr;
    logic [CNT_W-1:0] err_cnt_ff, nxt_err_cnt;

    logic enh_mode, div_mode, efr_on, rd_acc, wr_acc, flush;
    logic fifo_in_valid, fifo_ready, fifo_out_valid, pop, push, div_zero;
    logic [RXF_W-1:0] head;
    logic [CNT_W-1:0] rx_cnt;
    logic [7:0] ier_eff, trig_eff, line_status_reg, interrupt_status_reg, rd_mux;
    logic [3:0] isr_code;
    logic rx_cond, ls_cond, tx_cond, ms_cond;

    assign enh_mode = lcr_ff == LCR_ENH_KEY;
    assign div_mode = lcr_ff[LCR_DIV_BIT] && !enh_mode;
    assign efr_on = efr_ff[EFR_ENH_BIT];
    assign rd_acc = host_cs && host_rd;
    assign wr_acc = host_cs && host_wr;
    assign div_zero = (dll_ff == ZERO8) && (dlm_ff == ZERO8);
    assign ier_eff = efr_on ? ier_ff : (ier_ff & IER_STD_MASK);
    assign pop = rd_acc && host_addr == OFS_DATA && !enh_mode && !div_mode && fifo_out_valid;
    assign fifo_in_valid = rx_valid && (fifo_en_ff || rx_cnt == '0);
    assign push = fifo_in_valid && fifo_ready && !flush;
    assign flush = wr_acc && host_addr == OFS_ISR && !enh_mode && !(div_mode && efr_on)
        && (host_wdata[FCR_RXRST_BIT] || host_wdata[FCR_EN_BIT] != fifo_en_ff);
    assign trig_eff = (rx_trig_ff == ZERO8) ? RX_TRIG_RST : rx_trig_ff;

    uerp_fifo #(.WIDTH(RXF_W), .DEPTH(RXF_DEPTH), .CW(CNT_W)) u_rx_fifo (
        .clk(clk),
        .rst(rst),
        .flush(flush),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_ready),
        .in_data({rx_err, rx_data}),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(head),
        .count(rx_cnt)
    );

    always_comb begin
        // Receive status bits sit below bit 5 and at bit 7, transmit bits at 5 and 6.
        line_status_reg = ZERO8;
        line_status_reg[LSR_DR] = rx_cnt != '0;
        line_status_reg[LSR_OE] = overrun_ff;
        line_status_reg[4:2] = (rx_cnt != '0) ? head[RXF_W-1:DATA_W] : 3'b000;
        line_status_reg[LSR_THRE] = tx_empty;
        line_status_reg[LSR_TEMT] = tx_empty && tsr_empty;
        line_status_reg[LSR_GERR] = err_cnt_ff != '0;
        // Trigger level in FIFO mode, any character otherwise.
        rx_cond = fifo_en_ff ? (pad8(rx_cnt) >= trig_eff) : (rx_cnt != '0);
        ls_cond = ier_eff[IER_LS_BIT] && line_status_reg[4:1] != 4'h0;
        tx_cond = ier_eff[IER_TX_BIT] && tx_empty;
        ms_cond = ier_eff[IER_MS_BIT] && modem_int;
        if (ls_cond) begin
            isr_code = ISR_LSR;
        end else if (ier_eff[IER_RX_BIT] && rx_cond) begin
            isr_code = ISR_RXRDY;
        end else if (tx_cond) begin
            isr_code = ISR_TXRDY;
        end else if (ms_cond) begin
            isr_code = ISR_MSR;
        end else begin
            isr_code = ISR_NONE;
        end
        interrupt_status_reg = {{2{fifo_en_ff}}, 2'b00, isr_code};
        unique case (host_addr)
            OFS_DATA: rd_mux = enh_mode ? (feature_control_ff[FEATURE_CONTROL_RX_SEL_BIT] ? pad8(rx_cnt) : tx_level)
                : div_mode ? (div_zero ? REVISION_CODE : dll_ff) : head[DATA_W-1:0];
            OFS_IER: rd_mux = enh_mode ? feature_control_ff
                : div_mode ? (div_zero ? DEVICE_CODE : dlm_ff) : ier_eff;
            OFS_ISR: rd_mux = enh_mode ? efr_ff
                : (div_mode && efr_on) ? (dld_ff & DLD_MASK) : interrupt_status_reg;
            OFS_LCR: rd_mux = lcr_ff;
            OFS_RESUME1: rd_mux = enh_mode ? res1_ff : ZERO8;
            OFS_LSR: rd_mux = enh_mode ? res2_ff : line_status_reg;
            OFS_MSR: rd_mux = enh_mode ? pau1_ff : modem_status;
            OFS_PAUSE2: rd_mux = enh_mode ? pau2_ff : ZERO8;
        endcase
    end

    always_comb begin
        nxt_lcr = lcr_ff;
        nxt_ier = ier_ff;
        nxt_dll = dll_ff;
        nxt_dlm = dlm_ff;
        nxt_dld = dld_ff;
        nxt_efr = efr_ff;
        nxt_feature_control = feature_control_ff;
        nxt_rx_trig = rx_trig_ff;
        nxt_tx_trig = tx_trig_ff;
        nxt_res1 = res1_ff;
        nxt_res2 = res2_ff;
        nxt_pau1 = pau1_ff;
        nxt_pau2 = pau2_ff;
        nxt_fifo_en = fifo_en_ff;
        nxt_tx_wr = 1'b0;
        nxt_tx_data = tx_data_ff;
        nxt_rdata = rd_acc ? rd_mux : rdata_ff;
        nxt_irq = isr_code != ISR_NONE;
        nxt_overrun = overrun_ff;
        if (rd_acc && host_addr == OFS_LSR && !enh_mode) begin
            nxt_overrun = 1'b0;
        end
        if (rx_valid && !push) begin
            nxt_overrun = 1'b1;
        end
        nxt_err_cnt = CNT_W'(err_cnt_ff + CNT_W'(push && rx_err != '0)
            - CNT_W'(pop && head[RXF_W-1:DATA_W] != '0));
        if (flush) begin
            nxt_err_cnt = '0;
        end
        if (wr_acc) begin
            if (host_addr == OFS_LCR) begin
                nxt_lcr = host_wdata;
            end else if (enh_mode) begin
                unique case (host_addr)
                    OFS_DATA: begin
                        if (feature_control_ff[FEATURE_CONTROL_RX_SEL_BIT]) begin
                            nxt_rx_trig = host_wdata;
                        end else begin
                            nxt_tx_trig = host_wdata;
                        end
                    end
                    OFS_IER: nxt_feature_control = host_wdata & FEATURE_CONTROL_MASK;
                    OFS_ISR: nxt_efr = host_wdata & EFR_MASK;
                    OFS_RESUME1: nxt_res1 = host_wdata;
                    OFS_RESUME2: nxt_res2 = host_wdata;
                    OFS_PAUSE1: nxt_pau1 = host_wdata;
                    OFS_PAUSE2: nxt_pau2 = host_wdata;
                    default: nxt_lcr = lcr_ff;
                endcase
            end else if (div_mode && host_addr == OFS_DATA) begin
                nxt_dll = host_wdata;
            end else if (div_mode && host_addr == OFS_IER) begin
                nxt_dlm = host_wdata;
            end else if (div_mode && efr_on && host_addr == OFS_ISR) begin
                nxt_dld = host_wdata & DLD_MASK;
            end else if (host_addr == OFS_DATA) begin
                nxt_tx_wr = 1'b1;
                nxt_tx_data = host_wdata;
            end else if (host_addr == OFS_IER) begin
                nxt_ier = host_wdata & (efr_on ? IER_ENH_MASK : IER_STD_MASK);
            end else if (host_addr == OFS_ISR) begin
                nxt_fifo_en = host_wdata[FCR_EN_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lcr_ff <= ZERO8;
            ier_ff <= ZERO8;
            dll_ff <= ZERO8;
            dlm_ff <= ZERO8;
            dld_ff <= ZERO8;
            efr_ff <= ZERO8;
            feature_control_ff <= ZERO8;
            rx_trig_ff <= RX_TRIG_RST;
            tx_trig_ff <= TX_TRIG_RST;
            res1_ff <= ZERO8;
            res2_ff <= ZERO8;
            pau1_ff <= ZERO8;
            pau2_ff <= ZERO8;
            fifo_en_ff <= 1'b0;
            tx_wr_ff <= 1'b0;
            tx_data_ff <= ZERO8;
            rdata_ff <= ZERO8;
            irq_ff <= 1'b0;
            overrun_ff <= 1'b0;
            err_cnt_ff <= '0;
        end else begin
            lcr_ff <= nxt_lcr;
            ier_ff <= nxt_ier;
            dll_ff <= nxt_dll;
            dlm_ff <= nxt_dlm;
            dld_ff <= nxt_dld;
            efr_ff <= nxt_efr;
            feature_control_ff <= nxt_feature_control;
            rx_trig_ff <= nxt_rx_trig;
            tx_trig_ff <= nxt_tx_trig;
            res1_ff <= nxt_res1;
            res2_ff <= nxt_res2;
            pau1_ff <= nxt_pau1;
            pau2_ff <= nxt_pau2;
            fifo_en_ff <= nxt_fifo_en;
            tx_wr_ff <= nxt_tx_wr;
            tx_data_ff <= nxt_tx_data;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
            overrun_ff <= nxt_overrun;
            err_cnt_ff <= nxt_err_cnt;
        end
    end

    assign host_rdata = rdata_ff;
    assign irq = irq_ff;
    assign rx_ready = fifo_ready;
    assign tx_wr = tx_wr_ff;
    assign tx_data = tx_data_ff;
    assign baud_div = {dlm_ff, dll_ff};
    assign baud_frac = dld_ff[3:0];
    assign line_ctrl = lcr_ff;
    assign tx_trigger = tx_trig_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_rd(logic [2:0] a);
        host_cs && host_rd && host_addr == a;
    endsequence
    sequence s_lsr_rd;
        s_rd(OFS_LSR) ##0 !enh_mode;
    endsequence

    a_div_select: assert property (s_rd(OFS_DATA) ##0 (div_mode && !div_zero)
        |=> host_rdata == $past(dll_ff))
        else $error("divisor low byte not selected");
    a_enh_gate: assert property (s_rd(OFS_IER) ##0 (!enh_mode && !div_mode && !efr_on)
        |=> host_rdata[7:4] == 4'h0)
        else $error("enhanced enable bits visible while gated");
    a_src_gate: assert property ((ier_eff[3:0] == 4'h0) |=> !irq)
        else $error("interrupt raised with all sources masked");
    a_rx_trigger: assert property ((fifo_en_ff && ier_eff[IER_RX_BIT]
        && pad8(rx_cnt) >= trig_eff) |=> irq)
        else $error("trigger level reached without interrupt");
    a_isr_code: assert property (s_rd(OFS_ISR) ##0 (!enh_mode && !div_mode && !ls_cond
        && ier_eff[IER_RX_BIT] && rx_cond) |=> host_rdata[3:0] == ISR_RXRDY)
        else $error("receive trigger code missing");
    a_data_ready: assert property (s_lsr_rd |=> host_rdata[0] == $past(rx_cnt != '0))
        else $error("data ready flag wrong");
    a_overrun_set: assert property ((rx_valid && !push) |=> line_status_reg[LSR_OE])
        else $error("overrun not reported");
    a_head_err: assert property (s_lsr_rd ##0 (rx_cnt == '0)
        |=> host_rdata[4:2] == 3'b000)
        else $error("error bits shown with empty FIFO");
    a_tx_status: assert property (s_lsr_rd |=> host_rdata[6:5]
        == $past({tx_empty && tsr_empty, tx_empty}))
        else $error("transmit status bits wrong");
    a_global_err: assert property (s_lsr_rd |=> host_rdata[7] == $past(err_cnt_ff != '0))
        else $error("global error bit wrong");
    a_nonfifo_irq: assert property ((!fifo_en_ff && ier_eff[IER_RX_BIT] && rx_cnt != '0)
        |=> irq)
        else $error("held character without interrupt");
    a_frac_resv: assert property (s_rd(OFS_ISR) ##0 (div_mode && efr_on)
        |=> host_rdata[7:4] == 4'h0)
        else $error("fraction reserved bits not zero");
endmodule
`default_nettype wire

// >>> dv/uerp_line_model.sv
`timescale 1ns/1ns
`default_nettype none
// Stands in for the receiver and transmitter datapaths behind the register block.
// A character is offered until rx_ready is seen high, whether or not the block takes it; a stalled offer waits for rx_ready.
module uerp_line_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic send,
    input wire logic [7:0] send_data,
    input wire logic [2:0] send_err,
    output logic busy,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output logic [2:0] rx_err,
    input wire logic tx_wr,
    output logic tx_empty,
    output logic tsr_empty,
    output logic [7:0] tx_level
);
    logic [3:0] hold_ff;
    logic [3:0] shift_ff;

    assign busy = rx_valid;
    assign tx_empty = (hold_ff == 4'h0);
    assign tsr_empty = (shift_ff == 4'h0);
    assign tx_level = {7'h00, ~tx_empty};

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            rx_err <= 3'h0;
            hold_ff <= 4'h0;
            shift_ff <= 4'h0;
        end else begin
            if (send) begin
                rx_valid <= 1'b1;
                rx_data <= send_data;
                rx_err <= send_err;
            end else if (rx_valid && rx_ready) begin
                // A released line shows the inverse so stale data is never mistaken.
                rx_valid <= 1'b0;
                rx_data <= ~rx_data;
                rx_err <= ~rx_err;
            end
            if (tx_wr) begin
                hold_ff <= 4'h8;
            end else if (hold_ff == 4'h1) begin
                hold_ff <= 4'h0;
                shift_ff <= 4'h8;
            end else if (hold_ff != 4'h0) begin
                hold_ff <= hold_ff - 4'h1;
            end else if (shift_ff != 4'h0) begin
                shift_ff <= shift_ff - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/test_uerp_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_uerp_regs;
    import uerp_pkg::*;
    logic clk, rst, host_cs, host_rd, host_wr, irq, rx_valid, rx_ready, tx_wr;
    logic tx_empty, tsr_empty, modem_int, send_go, busy;
    logic [2:0] host_addr, rx_err, send_err;
    logic [7:0] host_wdata, host_rdata, rx_data, tx_data, tx_level, modem_status;
    logic [7:0] line_ctrl, tx_trigger, send_data;
    logic [15:0] baud_div;
    logic [3:0] baud_frac;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;

    uerp_regs uerp_regs_inst (.clk(clk), .rst(rst), .host_cs(host_cs), .host_rd(host_rd),
        .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .irq(irq), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .rx_err(rx_err), .tx_wr(tx_wr), .tx_data(tx_data),
        .tx_empty(tx_empty), .tsr_empty(tsr_empty), .tx_level(tx_level),
        .modem_status(modem_status), .modem_int(modem_int), .baud_div(baud_div),
        .baud_frac(baud_frac), .line_ctrl(line_ctrl), .tx_trigger(tx_trigger));

    uerp_line_model uerp_line_model_inst (.clk(clk), .rst(rst), .send(send_go),
        .send_data(send_data), .send_err(send_err), .busy(busy), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .rx_err(rx_err), .tx_wr(tx_wr),
        .tx_empty(tx_empty), .tsr_empty(tsr_empty), .tx_level(tx_level));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        host_cs <= 1'b1;
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge clk);
        host_cs <= 1'b0;
        host_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        host_cs <= 1'b1;
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge clk);
        host_cs <= 1'b0;
        host_rd <= 1'b0;
        @(negedge clk);
        chk(host_rdata, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic send(input logic [7:0] d, input logic [2:0] e);
        while (busy) @(posedge clk);
        @(posedge clk);
        send_go <= 1'b1;
        send_data <= d;
        send_err <= e;
        @(posedge clk);
        send_go <= 1'b0;
    endtask

    initial begin
        rst = 1'b1;
        host_cs = 1'b0;
        host_rd = 1'b0;
        host_wr = 1'b0;
        host_addr = 3'h0;
        host_wdata = 8'h00;
        modem_status = 8'hA5;
        modem_int = 1'b0;
        send_go = 1'b0;
        send_data = 8'h00;
        send_err = 3'h0;
        idle(8);
        rst <= 1'b0;
        rd(OFS_LSR, 8'h60);
        rd(OFS_ISR, 8'h01);
        rd(OFS_IER, 8'h00);
        chk(irq, 1'b0);
        wr(OFS_LCR, 8'h80);
        rd(3'h0, REVISION_CODE);
        chk(line_ctrl, 8'h80);
        rd(3'h1, DEVICE_CODE);
        wr(3'h0, 8'h34);
        wr(3'h1, 8'h12);
        rd(3'h0, 8'h34);
        rd(3'h1, 8'h12);
        chk(baud_div, 16'h1234);
        wr(OFS_LCR, 8'hBF);
        wr(3'h0, 8'h2A);
        rd(3'h0, 8'h00);
        chk(tx_trigger, 8'h2A);
        wr(3'h2, 8'hFF);
        rd(3'h2, 8'h3F);
        wr(3'h1, 8'hFF);
        rd(3'h1, 8'hF4);
        for (int a = 4; a < 8; a++) begin
            wr(a[2:0], 8'hC0 + 8'(a));
            rd(a[2:0], 8'hC0 + 8'(a));
        end
        wr(OFS_LCR, 8'h80);
        wr(3'h2, 8'hFA);
        rd(3'h2, 8'h0A);
        chk(baud_frac, 4'hA);
        wr(OFS_LCR, 8'h00);
        wr(OFS_IER, 8'hE0);
        rd(OFS_IER, 8'hE0);
        wr(OFS_LCR, 8'hBF);
        wr(3'h2, 8'h00);
        wr(OFS_LCR, 8'h00);
        rd(OFS_IER, 8'h00);
        wr(OFS_IER, 8'h01);
        send(8'h11, 3'h0);
        idle(3);
        rd(OFS_LSR, 8'h61);
        chk(irq, 1'b1);
        rd(OFS_ISR, 8'h04);
        send(8'h22, 3'h0);
        idle(3);
        rd(OFS_LSR, 8'h63);
        rd(OFS_LSR, 8'h61);
        rd(OFS_DATA, 8'h11);
        rd(OFS_LSR, 8'h60);
        idle(2);
        chk(irq, 1'b0);
        wr(OFS_ISR, 8'h01);
        wr(OFS_LCR, 8'hBF);
        wr(3'h1, 8'h80);
        wr(3'h0, 8'h03);
        rd(3'h0, 8'h00);
        wr(OFS_LCR, 8'h00);
        send(8'h31, 3'h0);
        send(8'h32, 3'h1);
        idle(3);
        rd(OFS_ISR, 8'hC1);
        chk(irq, 1'b0);
        send(8'h33, 3'h4);
        idle(3);
        rd(OFS_ISR, 8'hC4);
        chk(irq, 1'b1);
        rd(OFS_LSR, 8'hE1);
        rd(OFS_DATA, 8'h31);
        rd(OFS_ISR, 8'hC1);
        rd(OFS_LSR, 8'hE5);
        wr(OFS_IER, 8'h04);
        rd(OFS_ISR, 8'hC6);
        rd(OFS_DATA, 8'h32);
        rd(OFS_LSR, 8'hF1);
        rd(OFS_DATA, 8'h33);
        rd(OFS_LSR, 8'h60);
        wr(OFS_DATA, 8'h5A);
        @(negedge clk);
        chk(tx_data, 8'h5A);
        chk(tx_wr, 1'b1);
        rd(OFS_LSR, 8'h00);
        idle(10);
        rd(OFS_LSR, 8'h20);
        idle(10);
        rd(OFS_LSR, 8'h60);
        wr(OFS_IER, 8'h02);
        rd(OFS_ISR, 8'hC2);
        wr(OFS_IER, 8'h00);
        for (int i = 0; i < 33; i++) begin
            send(8'h40 + 8'(i), 3'h0);
        end
        idle(3);
        chk(rx_ready, 1'b0);
        wr(OFS_LCR, 8'hBF);
        rd(3'h0, 8'h20);
        wr(OFS_LCR, 8'h00);
        chk(irq, 1'b0);
        for (int i = 0; i < 33; i++) begin
            rd(OFS_DATA, 8'h40 + 8'(i));
        end
        rd(OFS_LSR, 8'h62);
        rd(OFS_LSR, 8'h60);
        rd(OFS_MSR, 8'hA5);
        send(8'h77, 3'h2);
        idle(3);
        rd(OFS_LSR, 8'hE9);
        wr(OFS_ISR, 8'h03);
        rd(OFS_LSR, 8'h60);
        wr(OFS_IER, 8'h08);
        @(posedge clk);
        modem_int <= 1'b1;
        rd(OFS_ISR, 8'hC0);
        idle(2);
        chk(irq, 1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
